// file: design/chz_pkg.sv
// Shared constants and types for the channelizer input port.
// Assumes a 32-bit APB master and a 200 MHz system clock.
package chz_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CHZ_CTRL_OFS = 8'h00;
    localparam logic [7:0] CHZ_STATUS_OFS = 8'h04;
    localparam logic [7:0] CHZ_SETCNT_OFS = 8'h08;
    localparam logic [5:0] CHZ_CTRL_RST = 6'h00;
    localparam int CHZ_OVF_BIT = 1;

    // ****************************************
    // Bus width codes and slice sizes
    // ****************************************
    localparam logic [1:0] CHZ_BW4 = 2'h0;
    localparam logic [1:0] CHZ_BW8 = 2'h1;
    localparam logic [1:0] CHZ_BW16 = 2'h2;
    localparam logic [1:0] CHZ_BW32 = 2'h3;
    localparam logic [7:0] CHZ_SLICE4 = 8'h04;
    localparam logic [7:0] CHZ_SLICE8 = 8'h08;
    localparam logic [7:0] CHZ_SLICE16 = 8'h10;
    localparam logic [7:0] CHZ_SLICE32 = 8'h20;

    // ****************************************
    // Bits per complete channel set
    // ****************************************
    localparam logic [7:0] CHZ_SET_REAL8 = 8'h20;
    localparam logic [7:0] CHZ_SET_CPLX8 = 8'h40;
    localparam logic [7:0] CHZ_SET_CPLX16 = 8'h80;
    localparam int CHZ_SET_W = 128;

    // Control fields, bit 0 upward: enable, lvds, width code, 16-bit, complex
    typedef struct packed {
        logic complex_set;
        logic sample16;
        logic [1:0] bus_width_select;
        logic lvds_mode;
        logic enable;
    } chz_ctrl_t;

    // One assembled set, slots packed from bit 0 in load order
    typedef struct packed {
        logic complex_set;
        logic sample16;
        logic [CHZ_SET_W-1:0] payload;
    } chz_set_t;

endpackage

// file: design/chz_input_port.sv
// Channelizer input port: samples the parallel sample bus, assembles channel sets.
// Assumes data_sample_clock_i and data_pins_i are asynchronous and much slower than clk_i.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps

// Contract
// RQ1: CMOS mode takes words only on the sample clock rising edge.
// RQ2: LVDS takes single rate at 4/8/16 bits, double rate at 32 bits.
// RQ3: Only eleven width/format combinations are legal; others stop assembly.
// RQ4: CMOS width code 00..11 selects pins 3:0, 7:0, 15:0, 31:0.
// RQ5: LVDS code 11 uses sixteen pairs on both clock edges.
// RQ6: Narrow buses build one set over consecutive sample clock cycles.
// RQ7: Channels fill 0 to 3; in-phase loads before quadrature.
// RQ8: 4-bit bus, 8-bit samples: two cycles per sample, 8 or 16 total.
// RQ9: 8-bit bus, 8-bit samples: one sample per cycle, 4 or 8 total.
// RQ10: Double rate rise slot from rising edge, fall slot from falling edge.
// RQ11: A configuration update restarts assembly at the first slot.
module chz_input_port import chz_pkg::*; (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic data_sample_clock_i,
    input wire logic [31:0] data_pins_i,
    output chz_set_t set_o,
    output logic set_valid_o,
    input wire logic set_ready_i
);

    // ****************************************
    // Declarations
    // ****************************************
    chz_ctrl_t ctrl_reg;
    logic ovf_reg;
    logic [15:0] set_cnt_reg;
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic dsc_meta_reg;
    logic dsc_sync_reg;
    logic dsc_prev_reg;
    logic [31:0] pins_meta_reg;
    logic [31:0] pins_sync_reg;
    logic [CHZ_SET_W-1:0] acc_reg;
    logic [CHZ_SET_W-1:0] acc_next;
    logic [6:0] ptr_reg;
    logic [7:0] load_idx_reg;
    logic rise_seen_reg;
    chz_set_t tail_reg;
    logic tail_valid_reg;
    logic rise;
    logic fall;
    logic ddr;
    logic cfg_ok;
    logic take;
    logic done;
    logic push;
    logic pop;
    logic in_ready;
    logic ctrl_wr;
    logic status_wr;
    logic access;
    logic first_acc;
    logic [7:0] slice_bits;
    logic [7:0] set_bits;
    logic [7:0] ptr_sum;
    chz_set_t in_set;

    // ****************************************
    // APB slave
    // ****************************************
    assign access = psel_i & penable_i & pready_reg;
    assign ctrl_wr = access & pwrite_i & (paddr_i == CHZ_CTRL_OFS);
    assign status_wr = access & pwrite_i & (paddr_i == CHZ_STATUS_OFS);
    assign first_acc = psel_i & penable_i & ~pready_reg;

    // One wait state, then answer
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= first_acc;
        end
    end

    // Read data and error stand for the answer cycle only
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            if (first_acc) begin
                unique case (paddr_i)
                    CHZ_CTRL_OFS: prdata_reg <= {26'h0, ctrl_reg};
                    CHZ_STATUS_OFS: prdata_reg <= {16'h0, load_idx_reg, 5'h0, tail_valid_reg, ovf_reg, ~cfg_ok};
                    CHZ_SETCNT_OFS: prdata_reg <= {16'h0, set_cnt_reg};
                    default: pslverr_reg <= 1'b1;
                endcase
            end
        end
    end

    assign pready_o = pready_reg;
    assign prdata_o = prdata_reg;
    assign pslverr_o = pslverr_reg;

    // Any control write also restarts assembly
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_reg <= chz_ctrl_t'(CHZ_CTRL_RST);
        end else if (ctrl_wr) begin
            ctrl_reg <= chz_ctrl_t'(pwdata_i[5:0]);
        end
    end

    // Overflow is sticky, write one to clear; a new overflow wins
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ovf_reg <= 1'b0;
        end else if (push & ~in_ready) begin
            ovf_reg <= 1'b1;
        end else if (status_wr & pwdata_i[CHZ_OVF_BIT]) begin
            ovf_reg <= 1'b0;
        end
    end

    // Sets accepted by the buffer; wraps
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            set_cnt_reg <= 16'h0000;
        end else if (push & in_ready) begin
            set_cnt_reg <= set_cnt_reg + 16'h0001;
        end
    end

    // ****************************************
    // Link synchronisers and edge detect
    // ****************************************
    // Link clock: two stages, a third for the edge detect
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            dsc_meta_reg <= 1'b0;
            dsc_sync_reg <= 1'b0;
            dsc_prev_reg <= 1'b0;
        end else begin
            dsc_meta_reg <= data_sample_clock_i;
            dsc_sync_reg <= dsc_meta_reg;
            dsc_prev_reg <= dsc_sync_reg;
        end
    end

    // Pins pass the same two stages, so a word lines up with its edge
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pins_meta_reg <= 32'h0000_0000;
            pins_sync_reg <= 32'h0000_0000;
        end else begin
            pins_meta_reg <= data_pins_i;
            pins_sync_reg <= pins_meta_reg;
        end
    end

    assign rise = dsc_sync_reg & ~dsc_prev_reg;
    assign fall = ~dsc_sync_reg & dsc_prev_reg;

    // ****************************************
    // Mode decode
    // ****************************************
    // RQ2: double rate only for LVDS at 32 bits
    assign ddr = ctrl_reg.lvds_mode & (ctrl_reg.bus_width_select == CHZ_BW32);

    // RQ3: real needs 8-bit samples, 16-bit needs at least 8 pins
    assign cfg_ok = ~(ctrl_reg.sample16 & ~ctrl_reg.complex_set)
                  & ~(ctrl_reg.sample16 & (ctrl_reg.bus_width_select == CHZ_BW4));

    always_comb begin
        // RQ4: width code picks the active pins
        unique case (ctrl_reg.bus_width_select)
            CHZ_BW4: slice_bits = CHZ_SLICE4;
            CHZ_BW8: slice_bits = CHZ_SLICE8;
            CHZ_BW16: slice_bits = CHZ_SLICE16;
            CHZ_BW32: slice_bits = CHZ_SLICE32;
        endcase
        // RQ5: sixteen pairs per edge in double rate
        if (ddr) begin
            slice_bits = CHZ_SLICE16;
        end
        if (~ctrl_reg.complex_set) begin
            set_bits = CHZ_SET_REAL8;
        end else if (~ctrl_reg.sample16) begin
            set_bits = CHZ_SET_CPLX8;
        end else begin
            set_bits = CHZ_SET_CPLX16;
        end
    end

    // RQ1: single rate takes rising edges only
    // RQ10: fall slot follows its rise slot
    assign take = ctrl_reg.enable & cfg_ok & (rise | (ddr & fall & rise_seen_reg));

    // ****************************************
    // Set assembly
    // ****************************************
    assign ptr_sum = {1'b0, ptr_reg} + slice_bits;
    assign done = take & (ptr_sum == set_bits);

    // RQ7: slots fill LSB first, I before Q, channel 0 upward
    // RQ8: 4-bit slices, two per 8-bit sample
    // RQ9: 8-bit slices, one per sample
    always_comb begin
        acc_next = acc_reg;
        unique case (slice_bits)
            CHZ_SLICE4: acc_next[ptr_reg +: 4] = pins_sync_reg[3:0];
            CHZ_SLICE8: acc_next[ptr_reg +: 8] = pins_sync_reg[7:0];
            CHZ_SLICE16: acc_next[ptr_reg +: 16] = pins_sync_reg[15:0];
            default: acc_next[ptr_reg +: 32] = pins_sync_reg;
        endcase
    end

    // RQ6: slot pointer advances once per captured word
    // RQ11: configuration write restarts at slot zero
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ptr_reg <= 7'h00;
        end else if (ctrl_wr) begin
            ptr_reg <= 7'h00;
        end else if (take) begin
            ptr_reg <= done ? 7'h00 : ptr_sum[6:0];
        end
    end

    // Words taken so far in the current set
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            load_idx_reg <= 8'h00;
        end else if (ctrl_wr) begin
            load_idx_reg <= 8'h00;
        end else if (take) begin
            load_idx_reg <= done ? 8'h00 : load_idx_reg + 8'h01;
        end
    end

    // Accumulator starts empty for every set
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_reg <= '0;
        end else if (ctrl_wr) begin
            acc_reg <= '0;
        end else if (take) begin
            acc_reg <= done ? '0 : acc_next;
        end
    end

    // RQ11: double rate waits for a rise after restart
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rise_seen_reg <= 1'b0;
        end else if (ctrl_wr) begin
            rise_seen_reg <= 1'b0;
        end else if (rise) begin
            rise_seen_reg <= 1'b1;
        end
    end

    // ****************************************
    // Two-entry output buffer
    // ****************************************
    assign in_set = '{complex_set: ctrl_reg.complex_set, sample16: ctrl_reg.sample16, payload: acc_next};
    assign push = done;
    // A pop frees the tail in the same cycle, so a set arriving then is kept
    assign in_ready = ~tail_valid_reg | pop;
    assign pop = set_valid_o & set_ready_i;

    // Head entry drives the output; refilled from the tail or the assembler
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            set_o <= '0;
            set_valid_o <= 1'b0;
        end else if (pop & tail_valid_reg) begin
            set_o <= tail_reg;
        end else if (pop | ~set_valid_o) begin
            set_o <= in_set;
            set_valid_o <= push;
        end
    end

    // Tail entry holds a second set while the head waits
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tail_reg <= '0;
            tail_valid_reg <= 1'b0;
        end else if (pop & tail_valid_reg) begin
            tail_reg <= in_set;
            tail_valid_reg <= push;
        end else if (set_valid_o & ~pop & push & ~tail_valid_reg) begin
            tail_reg <= in_set;
            tail_valid_reg <= 1'b1;
        end
    end

endmodule

// file: dv/chz_input_port_sva.sv
// Checker for the bus handshake and the set output of the input port.
// Sees only top-level ports; bound to every port instance below.
`timescale 1ns/1ps
module chz_input_port_sva import chz_pkg::*; (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire chz_set_t set_o,
    input wire logic set_valid_o,
    input wire logic set_ready_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ****
    // Bus answer
    // ****
    property p_rdy_pulse; pready_o |=> !pready_o; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held too long");
    property p_rdy_wait; psel_i && penable_i && !$past(penable_i) |-> !pready_o ##1 pready_o; endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("ready not after one wait");
    property p_rdy_acc; pready_o |-> psel_i && penable_i; endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
    property p_err_pair; pslverr_o |-> pready_o; endproperty
    a_err_pair: assert property (p_err_pair) else $error("error without ready");
    property p_rd_idle; !pready_o |-> prdata_o == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
    property p_unmap; pready_o && paddr_i > CHZ_SETCNT_OFS |-> pslverr_o; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped without error");
    property p_map; pready_o && paddr_i inside {8'h00, 8'h04, 8'h08} |-> !pslverr_o; endproperty
    a_map: assert property (p_map) else $error("mapped with error");
    // ****
    // Set output
    // ****
    property p_hold; set_valid_o && !set_ready_i |=> set_valid_o && $stable(set_o); endproperty
    a_hold: assert property (p_hold) else $error("set lost before taken");
    property p_shape; set_valid_o |-> !(set_o.sample16 && !set_o.complex_set)
        && (set_o.sample16 || set_o.payload[127:64] == 64'h0)
        && (set_o.complex_set || set_o.payload[127:32] == 96'h0); endproperty
    a_shape: assert property (p_shape) else $error("set shape illegal");
    c_set: cover property (set_valid_o && set_ready_i);
    c_err: cover property (pslverr_o);
    c_wide: cover property (set_valid_o && set_o.sample16);
endmodule

bind chz_input_port chz_input_port_sva chk_u (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .set_o(set_o), .set_valid_o(set_valid_o), .set_ready_i(set_ready_i));

// file: dv/chz_link_src.sv
// Sample source model: drives the link clock and the data pins.
// Clock stands low between words; pins invert, or take the fall word in double rate, once hold time ends.
`timescale 1ns/1ps
module chz_link_src (
    output logic dsc_o,
    output logic [31:0] pins_o
);
    initial begin
        dsc_o = 1'b0;
        pins_o = 32'h0;
    end
    // ****
    // One word, two in double rate, 80 ns
    // ****
    // rise then fall
    task automatic send(input logic [31:0] w, input logic [31:0] w2, input logic ddr);
        // Offsets keep every change but the final inversion clear of the system clock edges
        #1.25 pins_o = w;
        #20 dsc_o = 1'b1;
        #20 pins_o = ddr ? w2 : ~w;
        #20 dsc_o = 1'b0;
        #18.75 pins_o = ~pins_o;
    endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the channelizer input port.
// Drives the bus and the source model; takes sets by set_ready_i.
`timescale 1ns/1ps
module testbench import chz_pkg::*; ();
    localparam logic [3:0] CFG [11] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'hF};
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, set_ready_i = 1'b0;
    logic pready_o, pslverr_o, set_valid_o, data_sample_clock, err;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd, pins, q[$];
    logic [127:0] ex [3];
    chz_set_t set_o;
    int mismatches = 0, n_tests = 0;
    always #2.5 clk_i = ~clk_i;
    chz_link_src src_u (.dsc_o(data_sample_clock), .pins_o(pins));
    chz_input_port dut_u (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .data_sample_clock_i(data_sample_clock), .data_pins_i(pins),
        .set_o(set_o), .set_valid_o(set_valid_o), .set_ready_i(set_ready_i));
    // ****
    // Tasks
    // ****
    task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    function automatic logic [127:0] exp_set(input int sl);
        logic [127:0] p;
        p = '0;
        foreach (q[k]) p |= 128'(q[k] & ((33'h1 << sl) - 33'h1)) << (k * sl);
        return p;
    endfunction
    task automatic frame(input logic lv, input logic [1:0] bw, input int n);
        q.delete();
        for (int k = 0; k < n; k++) q.push_back($urandom());
        for (int k = 0; k < n; k += (lv && bw == CHZ_BW32) ? 2 : 1) src_u.send(q[k], q[(k + 1) % n], lv && bw == CHZ_BW32);
    endtask
    task automatic take(input logic [127:0] p, input logic [1:0] f);
        @(posedge clk_i);
        repeat (40) if (set_valid_o !== 1'b1) @(posedge clk_i);
        check("set valid", set_valid_o, 1'b1);
        check("set data", set_o.payload, p);
        check("set format", {set_o.complex_set, set_o.sample16}, f);
        set_ready_i <= 1'b1;
        @(posedge clk_i);
        set_ready_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // ****
    // Tests
    // ****
    initial begin
        logic [3:0] c;
        int sl;
        void'($urandom(32'hD47770FF));
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        apb(0, CHZ_CTRL_OFS, 32'h0);
        check("ctrl reset", rd, 32'(CHZ_CTRL_RST));
        apb(0, 8'h0C, 32'h0);
        check("unmapped", err, 1'b1);
        $display("test bus done");
        for (int m = 0; m < 22; m++) begin
            c = CFG[m % 11];
            sl = (m > 10 && c[3:2] == CHZ_BW32) ? 16 : (4 << c[3:2]);
            apb(1, CHZ_CTRL_OFS, {26'h0, c[0], c[1], c[3:2], 1'(m > 10), 1'b1});
            frame(m > 10, c[3:2], (c[1] ? 128 : c[0] ? 64 : 32) / sl);
            take(exp_set(sl), {c[0], c[1]});
        end
        $display("test combos done");
        apb(1, CHZ_CTRL_OFS, 32'h5);
        frame(0, CHZ_BW8, 2);
        apb(0, CHZ_STATUS_OFS, 32'h0);
        check("index mid", rd[15:8], 8'h02);
        apb(1, CHZ_CTRL_OFS, 32'h5);
        apb(0, CHZ_STATUS_OFS, 32'h0);
        check("index restart", rd[15:8], 8'h00);
        for (int k = 0; k < 3; k++) begin
            frame(0, CHZ_BW8, 4);
            ex[k] = exp_set(8);
        end
        apb(0, CHZ_STATUS_OFS, 32'h0);
        check("status full", rd[15:0], 16'h0006);
        take(ex[0], 2'b00);
        take(ex[1], 2'b00);
        apb(0, CHZ_SETCNT_OFS, 32'h0);
        check("set count", rd[15:0], 16'h0018);
        apb(1, CHZ_STATUS_OFS, 32'h2);
        apb(0, CHZ_STATUS_OFS, 32'h0);
        check("status clear", rd[2:0], 3'b000);
        $display("test buffer done");
        apb(1, CHZ_CTRL_OFS, 32'h15);
        frame(0, CHZ_BW8, 4);
        apb(0, CHZ_STATUS_OFS, 32'h0);
        check("illegal flag", rd[0], 1'b1);
        check("illegal set", set_valid_o, 1'b0);
        $display("test illegal done");
        final_report();
    end
    initial begin
        #200000;
        mismatches++;
        final_report();
    end
endmodule
